// ===== rtl/duhp_defs.svh
// Constants for the dual UART host bus pin block.
`ifndef DUHP_DEFS_SVH
`define DUHP_DEFS_SVH
`define DUHP_ADDR_MODE 4'h0
`define DUHP_ADDR_STAT_A 4'h1
`define DUHP_ADDR_THRA 4'h3
`define DUHP_ADDR_MASK 4'h5
`define DUHP_ADDR_IRQ_STAT 4'h5
`define DUHP_ADDR_MODE_B 4'h8
`define DUHP_ADDR_STAT_B 4'h9
`define DUHP_ADDR_THRB 4'hb
`define DUHP_ADDR_PORT_CFG 4'hd
`define DUHP_ADDR_OPSET 4'he
`define DUHP_ADDR_OPCLR 4'hf
`define DUHP_SR_TXRDY 2
`define DUHP_IRQ_TXA 0
`define DUHP_IRQ_RXA 1
`define DUHP_IRQ_TXB 4
`define DUHP_IRQ_RXB 5
`define DUHP_DIV_RESET 8'h0a
`define DUHP_BYTE_ZERO 8'h00
`endif

// ===== rtl/duhp_pkg.sv
// Types for the dual UART host bus pin block.
`default_nettype none
package duhp_pkg;
    // Bus access phases of the strobe handler.
    typedef enum logic [1:0] {
        DUHP_IDLE,
        DUHP_READ,
        DUHP_WRITE
    } duhp_bus_t;
    // Transmitter state: ten bit times per frame.
    typedef struct packed {
        logic busy;
        logic [9:0] shift;
        logic [3:0] left;
        logic [7:0] div;
    } duhp_tx_t;
    // Whole module state.
    typedef struct packed {
        duhp_bus_t bus;
        logic [3:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [1:0] mr_ptr;
        logic [7:0] irq_mask;
        logic [7:0] irq_stat;
        logic [7:0] port_val;
        logic [7:0] port_cfg;
        logic [7:0] stat_a;
        logic [7:0] stat_b;
        duhp_tx_t txa;
        duhp_tx_t txb;
        logic [2:0] ws;
        logic [2:0] rs;
        logic [2:0] cs;
    } duhp_state_t;
endpackage : duhp_pkg
`default_nettype wire

// ===== rtl/duhp_top.sv
// Dual UART host bus pins: strobe bus, reset effects, interrupt and serial outputs.
// Functional notes
// - Eight bit data bus, bit zero LSB.
// - Chip select high floats the data bus.
// - Write captured, completes on strobe rising edge.
// - Read drives addressed register from strobe fall.
// - Reset clears status, mask, port registers.
// - Reset drives port high, lines mark.
// - Reset returns mode pointer to first.
// - Open drain interrupt low on unmasked condition.
// - Transmitters send data LSB first.
// - Transmit line mark when idle or looped.
// - Pins zero, one: output only.
// - Pin two: output or channel A clocks.
// - Pin three: output, timer or B clocks.
// - Pins four to six mirror interrupt bits.
// - Pin seven mirrors transmitter B interrupt.
`timescale 1ns/100ps
`default_nettype none
`include "duhp_defs.svh"
module duhp_top
    import duhp_pkg::*;
#(
    parameter logic [7:0] BIT_DIV = `DUHP_DIV_RESET
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic chip_select_n_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic [7:0] data_oe_n_o,
    input wire logic serial_in_a_i,
    input wire logic serial_in_b_i,
    input wire logic loopback_a_i,
    input wire logic loopback_b_i,
    input wire logic [7:0] events_i,
    input wire logic timer_out_i,
    input wire logic [3:0] ext_clk_i,
    output logic serial_out_a_o,
    output logic serial_out_b_o,
    output logic irq_request_o,
    output logic irq_request_oe_n_o,
    output logic [7:0] out_pin_o,
    output logic [7:0] out_pin_oe_n_o,
    output logic [1:0] mode_reg_pointer_o
);
    // Registered state and its next value.
    duhp_state_t s_q;
    duhp_state_t s_d;
    // Synchronisers for the asynchronous strobes and serial inputs.
    logic [2:0] str_m_q;
    logic [2:0] str_s_q;
    logic [1:0] rx_m_q;
    logic [1:0] rx_s_q;
    logic [3:0] ec_m_q;
    logic [3:0] ec_s_q;
    logic [3:0] ec_d_q;
    logic [11:0] ad_m_q; // Data and address pins, first stage.
    logic [11:0] ad_s_q; // Second stage, aligned with the strobes so both arrive together.
    logic selected;
    logic rd_act;
    logic wr_rise;
    logic [3:0] ec_rise;
    logic [3:0] ec_fall;

    // Register file read mux, shared by the read path.
    function automatic logic [7:0] rd_mux(input duhp_state_t st, input logic [3:0] a);
        case (a)
            `DUHP_ADDR_STAT_A: rd_mux = st.stat_a;
            `DUHP_ADDR_STAT_B: rd_mux = st.stat_b;
            `DUHP_ADDR_IRQ_STAT: rd_mux = st.irq_stat;
            `DUHP_ADDR_PORT_CFG: rd_mux = st.port_cfg;
            default: rd_mux = `DUHP_BYTE_ZERO;
        endcase
    endfunction : rd_mux

    // One bit time step of a transmitter, LSB first after the start bit.
    function automatic duhp_tx_t tx_step(input duhp_tx_t t, input logic go,
                                         input logic [7:0] b, input logic tick);
        tx_step = t;
        if (!t.busy && go) begin
            tx_step.busy = 1'b1;
            tx_step.shift = {1'b1, b, 1'b0};
            tx_step.left = 4'd10;
            tx_step.div = BIT_DIV;
        end else if (t.busy && tick) begin
            if (t.div == `DUHP_BYTE_ZERO) begin
                tx_step.div = BIT_DIV;
                tx_step.shift = {1'b1, t.shift[9:1]};
                tx_step.left = t.left - 4'd1;
                tx_step.busy = (t.left != 4'd1);
            end else begin
                tx_step.div = t.div - 8'd1;
            end
        end
    endfunction : tx_step

    // Two-flop synchronisers; only the second stage feeds logic, except the third ext clock stage ec_d_q used for edges.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            str_m_q <= 3'b111;
            str_s_q <= 3'b111;
            rx_m_q <= 2'b11;
            rx_s_q <= 2'b11;
            ec_m_q <= 4'h0;
            ec_s_q <= 4'h0;
            ec_d_q <= 4'h0;
            ad_m_q <= 12'h000;
            ad_s_q <= 12'h000;
        end else begin
            str_m_q <= {chip_select_n_i, read_strobe_n_i, write_strobe_n_i};
            str_s_q <= str_m_q;
            rx_m_q <= {serial_in_b_i, serial_in_a_i};
            rx_s_q <= rx_m_q;
            ec_m_q <= ext_clk_i;
            ec_s_q <= ec_m_q;
            ec_d_q <= ec_s_q;
            ad_m_q <= {data_i, addr_i};
            ad_s_q <= ad_m_q;
        end
    end

    assign ec_rise = ec_s_q & ~ec_d_q;
    assign ec_fall = ~ec_s_q & ec_d_q;
    assign selected = ~str_s_q[2];
    assign rd_act = selected & ~str_s_q[1];
    // Write completes when the strobe rises while the access was a write.
    assign wr_rise = str_s_q[0] & (s_q.bus == DUHP_WRITE);

    // Next-state logic for the bus, registers and transmitters.
    always_comb begin
        s_d = s_q;
        s_d.ws = str_s_q;
        s_d.rs = {1'b0, rx_s_q};
        s_d.cs = {ec_rise[2:0]};
        // Hardware events set sticky interrupt status; the transmitter bits follow the ready flags instead.
        s_d.irq_stat = s_q.irq_stat | events_i;
        s_d.irq_stat[`DUHP_IRQ_TXA] = ~s_q.txa.busy;
        s_d.irq_stat[`DUHP_IRQ_TXB] = ~s_q.txb.busy;
        s_d.stat_a[`DUHP_SR_TXRDY] = ~s_q.txa.busy;
        s_d.stat_b[`DUHP_SR_TXRDY] = ~s_q.txb.busy;
        case (s_q.bus)
            DUHP_IDLE: begin
                // Both strobes together is illegal; read is favoured then.
                if (rd_act) begin
                    s_d.bus = DUHP_READ;
                    s_d.rdata = rd_mux(s_q, ad_s_q[3:0]);
                end else if (selected && !str_s_q[0]) begin
                    s_d.bus = DUHP_WRITE;
                    s_d.addr = ad_s_q[3:0];
                    s_d.wdata = ad_s_q[11:4];
                end
            end
            DUHP_READ: begin
                if (!rd_act) begin
                    s_d.bus = DUHP_IDLE;
                end
            end
            DUHP_WRITE: begin
                // Keep tracking data until the strobe rises.
                if (!str_s_q[0]) begin
                    s_d.wdata = ad_s_q[11:4];
                    s_d.addr = ad_s_q[3:0];
                end else begin
                    s_d.bus = DUHP_IDLE;
                end
            end
            default: s_d.bus = DUHP_IDLE;
        endcase
        s_d.txa = tx_step(s_q.txa, wr_rise && s_q.addr == `DUHP_ADDR_THRA, s_q.wdata, 1'b1);
        s_d.txb = tx_step(s_q.txb, wr_rise && s_q.addr == `DUHP_ADDR_THRB, s_q.wdata, 1'b1);
        if (wr_rise) begin
            case (s_q.addr)
                `DUHP_ADDR_MODE: s_d.mr_ptr = (s_q.mr_ptr == 2'd1) ? 2'd2 : s_q.mr_ptr;
                `DUHP_ADDR_MASK: s_d.irq_mask = s_q.wdata;
                `DUHP_ADDR_PORT_CFG: s_d.port_cfg = s_q.wdata;
                `DUHP_ADDR_OPSET: s_d.port_val = s_q.port_val | s_q.wdata;
                `DUHP_ADDR_OPCLR: s_d.port_val = s_q.port_val & ~s_q.wdata;
                default: s_d.addr = s_q.addr;
            endcase
        end
    end

    // State register; reset clears status, mask and port registers.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.mr_ptr <= 2'd1;
            s_q.txa.shift <= 10'h3ff;
            s_q.txb.shift <= 10'h3ff;
            s_q.ws <= 3'b111;
        end else begin
            s_q <= s_d;
        end
    end

    // Data bus drives only during a selected read.
    assign data_o = s_q.rdata;
    assign data_oe_n_o = (s_q.bus == DUHP_READ && rd_act) ? 8'h00 : 8'hff;

    // Transmit lines sit at mark when idle or looped back.
    assign serial_out_a_o = (loopback_a_i || !s_q.txa.busy) ? 1'b1 : s_q.txa.shift[0];
    assign serial_out_b_o = (loopback_b_i || !s_q.txb.busy) ? 1'b1 : s_q.txb.shift[0];

    // Open-drain request pulls low on any unmasked condition.
    assign irq_request_o = 1'b0;
    assign irq_request_oe_n_o = ~|(s_q.irq_stat & s_q.irq_mask);

    // Port pins are the complement of the value register unless port_cfg selects another source; reset makes all high.
    always_comb begin
        out_pin_o = ~s_q.port_val;
        out_pin_oe_n_o = 8'h00;
        out_pin_o[0] = ~s_q.port_val[0];
        out_pin_o[1] = ~s_q.port_val[1];
        out_pin_o[2] = s_q.port_cfg[0] ? ec_s_q[0] : ~s_q.port_val[2];
        if (s_q.port_cfg[3:2] == 2'b01) begin
            out_pin_o[3] = 1'b0;
            out_pin_oe_n_o[3] = timer_out_i;
        end else if (s_q.port_cfg[3:2] != 2'b00) begin
            out_pin_o[3] = ec_s_q[2];
        end
        if (s_q.port_cfg[4]) begin
            out_pin_o[4] = 1'b0;
            out_pin_oe_n_o[4] = ~s_q.irq_stat[`DUHP_IRQ_RXA];
        end
        if (s_q.port_cfg[5]) begin
            out_pin_o[5] = 1'b0;
            out_pin_oe_n_o[5] = ~s_q.irq_stat[`DUHP_IRQ_RXB];
        end
        if (s_q.port_cfg[6]) begin
            out_pin_o[6] = 1'b0;
            out_pin_oe_n_o[6] = ~s_q.irq_stat[`DUHP_IRQ_TXA];
        end
        if (s_q.port_cfg[7]) begin
            out_pin_o[7] = 1'b0;
            out_pin_oe_n_o[7] = ~s_q.irq_stat[`DUHP_IRQ_TXB];
        end
    end

    assign mode_reg_pointer_o = s_q.mr_ptr;

    // Synchronised serial inputs and clock edges feed no logic; folded here only to keep them used.
    logic unused_rx;
    assign unused_rx = ^{s_q.rs, s_q.cs, ec_fall[3], ec_rise[3]};

    // A read opens when the strobe is seen low while the bus handler is idle.
    sequence s_read_open;
        s_q.bus == DUHP_IDLE && rd_act;
    endsequence
    // Checked against the raw pin two clocks back, so the synchroniser is covered too.
    a_float_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        $past(chip_select_n_i, 2) |-> data_oe_n_o == 8'hff)
        else $error("bus driven while deselected");
    a_irq_follow: assert property (@(posedge clk_i) disable iff (reset_i)
        (|(s_q.irq_stat & s_q.irq_mask)) |-> !irq_request_oe_n_o)
        else $error("irq not pulled");
    a_tx_mark: assert property (@(posedge clk_i) disable iff (reset_i)
        (!s_q.txa.busy || loopback_a_i) |-> serial_out_a_o)
        else $error("tx a not mark");
    a_tx_mark_b: assert property (@(posedge clk_i) disable iff (reset_i)
        (!s_q.txb.busy || loopback_b_i) |-> serial_out_b_o)
        else $error("tx b not mark");
    a_write_mask: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_rise && s_q.addr == `DUHP_ADDR_MASK) |=> s_q.irq_mask == $past(s_q.wdata))
        else $error("mask not written");
    a_read_drive: assert property (@(posedge clk_i) disable iff (reset_i)
        s_read_open |=> (rd_act |-> data_oe_n_o == 8'h00))
        else $error("read not driven");
    a_tx_start: assert property (@(posedge clk_i) disable iff (reset_i)
        (!s_q.txa.busy && wr_rise && s_q.addr == `DUHP_ADDR_THRA && !loopback_a_i)
        |=> (loopback_a_i || !serial_out_a_o)) else $error("no start bit");
    a_pin7_irq: assert property (@(posedge clk_i) disable iff (reset_i)
        (s_q.port_cfg[7] && s_q.irq_stat[`DUHP_IRQ_TXB]) |-> !out_pin_oe_n_o[7])
        else $error("pin seven idle");
endmodule : duhp_top
`default_nettype wire

// ===== sim/duhp_cpu_model.sv
// Processor model that drives the separate read and write strobe port.
`timescale 1ns/100ps
`default_nettype none
module duhp_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] dev_data_i,
    input wire logic [7:0] dev_oe_n_i,
    output logic chip_select_n_o,
    output logic write_strobe_n_o,
    output logic read_strobe_n_o,
    output logic [3:0] addr_o,
    output logic [7:0] data_o
);
    logic [7:0] bus; // Level on the shared wires, seen by this model.
    // Only the separate strobe style is spoken here, as if the style pin were high.
    initial begin
        chip_select_n_o = 1'b1;
        write_strobe_n_o = 1'b1;
        read_strobe_n_o = 1'b1;
        addr_o = 4'h0;
        data_o = 8'h00;
    end
    // Each wire shows the device while its driver is on, else our own level.
    always_comb bus = (dev_data_i & ~dev_oe_n_i) | (data_o & dev_oe_n_i);
    // Strobes are held at least six clocks so the two-flop synchronisers see them.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        chip_select_n_o <= 1'b0;
        addr_o <= a;
        data_o <= d;
        write_strobe_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        write_strobe_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        chip_select_n_o <= 1'b1;
        data_o <= ~d; // Released lines never keep the last value.
        repeat (4) @(posedge clk_i);
    endtask : wr
    // Read data is taken at the edge just before the strobe is released.
    task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic [7:0] oe);
        @(posedge clk_i);
        chip_select_n_o <= 1'b0;
        addr_o <= a;
        read_strobe_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        d = bus;
        oe = dev_oe_n_i;
        read_strobe_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        chip_select_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask : rd
endmodule : duhp_cpu_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the dual UART host bus pin block.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [7:0] DIV = 8'h03; // Short bit time keeps the run brief.
    localparam int BT = 4; // Clocks per bit, the divider plus one.
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cs_n, wr_n, rd_n, sa, sb, irq, irq_oe_n;
    logic [3:0] addr;
    logic [1:0] mptr;
    logic [7:0] wdata, rdata, d_oe_n, pins, pins_oe_n, got, oe, r, m, lo;
    logic sin_a = 1'b1;
    logic sin_b = 1'b1;
    logic lb_a = 1'b0;
    logic lb_b = 1'b0;
    logic tmr = 1'b0;
    logic [3:0] xclk = 4'h0;
    logic [3:0] xq1; // External clocks one edge back.
    logic [3:0] xq2; // Two edges back, as the port pins show them after synchronising.
    logic [7:0] evts = 8'h00;
    logic [31:0] seed = 32'ha6b7;
    int n_fail = 0;
    int checks = 0;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // Line inputs wander at random so the synchronisers see real traffic.
    always @(posedge clk_i) begin
        seed <= lfsr(seed);
        {sin_a, sin_b, tmr, xclk} <= seed[6:0];
        xq1 <= xclk;
        xq2 <= xq1;
    end
    duhp_top #(.BIT_DIV(DIV)) dut (.clk_i(clk_i), .reset_i(reset_i), .chip_select_n_i(cs_n),
        .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .addr_i(addr), .data_i(wdata),
        .data_o(rdata), .data_oe_n_o(d_oe_n), .serial_in_a_i(sin_a), .serial_in_b_i(sin_b),
        .loopback_a_i(lb_a), .loopback_b_i(lb_b), .events_i(evts), .timer_out_i(tmr),
        .ext_clk_i(xclk), .serial_out_a_o(sa), .serial_out_b_o(sb), .irq_request_o(irq),
        .irq_request_oe_n_o(irq_oe_n), .out_pin_o(pins), .out_pin_oe_n_o(pins_oe_n),
        .mode_reg_pointer_o(mptr));
    duhp_cpu_model cpu (.clk_i(clk_i), .dev_data_i(rdata), .dev_oe_n_i(d_oe_n),
        .chip_select_n_o(cs_n), .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n),
        .addr_o(addr), .data_o(wdata));
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH at %0t: %0s got %h expected %h", $time, what, g, e);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // One-clock event pulse, then time for the status to settle.
    task automatic pulse(input logic [7:0] e);
        @(posedge clk_i);
        evts <= e;
        @(posedge clk_i);
        evts <= 8'h00;
        repeat (6) @(posedge clk_i);
    endtask : pulse
    // Catches one frame mid-bit: start bit, eight bits low first, stop bit.
    task automatic frame(input logic b, output logic [7:0] d);
        logic ln;
        ln = 1'b1;
        for (int i = 0; i < 200 && ln === 1'b1; i++) begin
            @(posedge clk_i);
            ln = b ? sb : sa;
        end
        repeat (BT / 2) @(posedge clk_i);
        chk({7'h00, b ? sb : sa}, 8'h00, "start bit");
        for (int i = 0; i < 8; i++) begin
            repeat (BT) @(posedge clk_i);
            d[i] = b ? sb : sa;
        end
        repeat (BT) @(posedge clk_i);
        chk({7'h00, b ? sb : sa}, 8'h01, "stop bit");
    endtask : frame
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        chk(pins, 8'hff, "port in reset");
        chk({6'h00, sa, sb}, 8'h03, "lines in reset");
        chk(d_oe_n, 8'hff, "bus in reset");
        chk({6'h00, mptr}, 8'h01, "mode pointer");
        reset_i <= 1'b0;
        cpu.rd(4'h5, got, oe);
        // Cleared by reset; only the ready bits of both idle transmitters come back at once.
        chk(got, 8'h11, "status after reset");
        chk(oe, 8'h00, "bus driven in read");
        chk(d_oe_n, 8'hff, "bus floated when idle");
        cpu.rd(4'h2, got, oe);
        chk(got, 8'h00, "unmapped read");
        $display("test reset done");
        r = seed[7:0];
        m = seed[15:8];
        cpu.wr(4'he, r);
        chk(pins, ~r, "port set");
        cpu.wr(4'hf, m);
        chk(pins, ~(r & ~m), "port clear");
        chk(pins_oe_n, 8'h00, "port driven");
        $display("test port done");
        cpu.wr(4'h5, 8'h22);
        pulse(8'h01);
        chk({7'h00, irq_oe_n}, 8'h01, "masked off event");
        pulse(8'h02);
        chk({7'h00, irq_oe_n}, 8'h00, "enabled event");
        chk({7'h00, irq}, 8'h00, "open drain level");
        cpu.rd(4'h5, got, oe);
        chk(got, 8'h13, "sticky status");
        cpu.wr(4'hd, 8'hf0);
        // Receiver A event set, receiver B clear, both transmitters idle and ready.
        chk({4'h0, pins_oe_n[7:4]}, 8'h02, "interrupt mirrors");
        cpu.wr(4'h0, 8'h00);
        chk({6'h00, mptr}, 8'h02, "pointer advances");
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        chk({6'h00, mptr}, 8'h01, "pointer back to first");
        chk(pins_oe_n, 8'h00, "config cleared");
        chk(pins, 8'hff, "value cleared");
        pulse(8'h02);
        chk({7'h00, irq_oe_n}, 8'h01, "mask cleared");
        $display("test interrupt done");
        cpu.wr(4'hd, 8'h05);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            chk({7'h00, pins[2]}, {7'h00, xq2[0]}, "pin two clock");
            chk({7'h00, pins_oe_n[3]}, {7'h00, tmr}, "pin three timer");
        end
        cpu.wr(4'hd, 8'h08);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            chk({7'h00, pins[3]}, {7'h00, xq2[2]}, "pin three clock");
        end
        $display("test pins done");
        for (int c = 0; c < 2; c++) begin
            r = seed[7:0];
            fork
                cpu.wr(c ? 4'hb : 4'h3, r);
                frame(c[0], got);
            join
            chk(got, r, "transmit byte");
        end
        $display("test serial done");
        lb_a <= 1'b1;
        lb_b <= 1'b1;
        lo = 8'h00;
        fork
            cpu.wr(4'h3, 8'h00);
            repeat (80) begin
                @(posedge clk_i);
                if (sa !== 1'b1 || sb !== 1'b1) lo++;
            end
        join
        chk(lo, 8'h00, "loopback mark");
        $display("test loopback done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
